/* logic/i2c_buf2.sv */
// Small shift-style buffer with valid and ready on both sides.
// Assumes one clock; the head entry always sits in slot zero.
`timescale 1ns/1ps
`default_nettype none
module i2c_buf2 #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic [DEPTH-1:0][W-1:0] ent_q, ent_d, sh_e;
   logic [DEPTH-1:0] v_q, v_d, sh_v;
   logic pop, push;

   assign pop = v_q[0] & out_ready;
   assign push = in_valid & ~v_q[DEPTH-1];

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      if (i < DEPTH - 1) begin : g_mid
         assign sh_v[i] = pop ? v_q[i+1] : v_q[i];
         assign sh_e[i] = pop ? ent_q[i+1] : ent_q[i];
      end else begin : g_top
         assign sh_v[i] = pop ? 1'b0 : v_q[i];
         assign sh_e[i] = ent_q[i];
      end
      // The new word lands in the lowest free slot after the shift.
      if (i == 0) begin : g_first
         assign v_d[i] = sh_v[i] | push;
         assign ent_d[i] = (push && !sh_v[i]) ? in_data : sh_e[i];
      end else begin : g_rest
         assign v_d[i] = sh_v[i] | (push & sh_v[i-1]);
         assign ent_d[i] = (push && !sh_v[i] && sh_v[i-1]) ? in_data : sh_e[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ent_q <= '0;
         v_q <= '0;
      end else begin
         ent_q <= ent_d;
         v_q <= v_d;
      end
   end

   assign in_ready = ~v_q[DEPTH-1];
   assign out_valid = v_q[0];
   assign out_data = ent_q[0];
endmodule
`default_nettype wire

/* logic/i2c_params.svh */
// Constants of the two-wire status-code controller: control bit positions,
// status codes, reset values and bus timing.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef I2C_PARAMS_SVH
`define I2C_PARAMS_SVH

`define I2C_CLK_PERIOD_PS 5000
`define I2C_SCL_HALF_NS 80
`define I2C_SCL_HALF_CYC (((`I2C_SCL_HALF_NS * 1000) + `I2C_CLK_PERIOD_PS - 1) / `I2C_CLK_PERIOD_PS)
`define I2C_TMR_W 16

`define I2C_CTL_AA 2
`define I2C_CTL_SI 3
`define I2C_CTL_STO 4
`define I2C_CTL_STA 5
`define I2C_CTL_EN 6
`define I2C_CTL_SET_MASK 8'h74
`define I2C_CTL_CLR_MASK 8'h6c
`define I2C_CTL_RESET 8'h00
`define I2C_CODE_RESET 8'hf8
`define I2C_GC_ADDR 8'h00

`define I2C_SC_BUS_ERR 8'h00
`define I2C_SC_START 8'h08
`define I2C_SC_RSTART 8'h10
`define I2C_SC_MT_AW_ACK 8'h18
`define I2C_SC_MT_AW_NACK 8'h20
`define I2C_SC_MT_D_ACK 8'h28
`define I2C_SC_MT_D_NACK 8'h30
`define I2C_SC_ARB_LOST 8'h38
`define I2C_SC_MR_AR_ACK 8'h40
`define I2C_SC_MR_AR_NACK 8'h48
`define I2C_SC_MR_D_ACK 8'h50
`define I2C_SC_MR_D_NACK 8'h58
`define I2C_SC_SR_AW 8'h60
`define I2C_SC_SR_AW_LOST 8'h68
`define I2C_SC_SR_GC 8'h70
`define I2C_SC_SR_GC_LOST 8'h78
`define I2C_SC_SR_D_ACK 8'h80
`define I2C_SC_SR_D_NACK 8'h88
`define I2C_SC_GC_D_ACK 8'h90
`define I2C_SC_GC_D_NACK 8'h98
`define I2C_SC_SR_STOP 8'ha0
`define I2C_SC_ST_AR 8'ha8
`define I2C_SC_ST_AR_LOST 8'hb0
`define I2C_SC_ST_D_ACK 8'hb8
`define I2C_SC_ST_D_NACK 8'hc0
`define I2C_SC_ST_LAST 8'hc8

`endif

/* logic/i2c_pkg.sv */
// Types shared by the two-wire status-code controller.
// Assumes nothing beyond a SystemVerilog compiler.
package i2c_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_START = 4'b0001,
      ST_RST_LO = 4'b0010,
      ST_RST_HI = 4'b0011,
      ST_XFER = 4'b0100,
      ST_POST = 4'b0101,
      ST_HOLD = 4'b0110,
      ST_STOP_LO = 4'b0111,
      ST_STOP_HI = 4'b1000
   } ctl_state_t;
endpackage

/* logic/i2c_status_state_machine.sv */
// Byte-level two-wire bus controller: master and slave, transmit and
// receive, posting a status code and an interrupt flag for each event.
// Assumes open-drain pins resolved outside and software on plain ports.
`include "i2c_params.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_status_state_machine #(
   parameter int unsigned HALF_CYC = `I2C_SCL_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic control_set_wr,
   input wire logic [7:0] control_set_port,
   input wire logic control_clear_wr,
   input wire logic [7:0] control_clear_port,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic [6:0] own_address,
   input wire logic general_call_en,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [7:0] bus_state_code,
   output logic [7:0] byte_shift_holder,
   output logic interrupt_flag,
   output logic assert_ack_bit,
   output logic start_request_bit,
   output logic stop_request_bit,
   output logic interface_enable,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   localparam logic [`I2C_TMR_W-1:0] HALF_M1 = `I2C_TMR_W'(HALF_CYC - 1);

   i2c_pkg::ctl_state_t state_q, state_d;
   logic [7:0] ctl_q, ctl_d, code_q, code_d, hold_q, hold_d, sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic [`I2C_TMR_W-1:0] tmr_q, tmr_d;
   logic rs_q, rs_d, mlow_q, mlow_d, drv_q, drv_d, mst_q, mst_d, tx_q, tx_d;
   logic aph_q, aph_d, dir_q, dir_d, addr_q, addr_d, gc_q, gc_d, lost_q, lost_d;
   logic last_q, last_d, ack_q, ack_d, rep_q, rep_d, busy_q, busy_d, push_q, push_d;
   logic scl_p_q, sda_p_q, scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;
   logic half_done, addr_hit, si_set, buf_ready;

   ////////////////////////////////////////////////////////////////////////
   i2c_sync3 #(
      .W(2)
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({scl_i, sda_i}),
      .level({scl_s, sda_s})
   );

   // A full receive buffer stalls the posting step, which keeps the
   // clock low, so the far side waits instead of losing a byte.
   i2c_buf2 #(
      .W(8),
      .DEPTH(2)
   ) u_rxbuf (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(state_q == i2c_pkg::ST_POST && push_q),
      .in_data(hold_q),
      .in_ready(buf_ready),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(rx_ready)
   );

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_seen = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign half_done = tmr_q >= HALF_M1;
   assign addr_hit = ctl_q[`I2C_CTL_EN] & ctl_q[`I2C_CTL_AA] &
      ((sh_q[7:1] == own_address) | (general_call_en & (sh_q == `I2C_GC_ADDR)));

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      ctl_d = ctl_q;
      code_d = code_q;
      hold_d = hold_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      tmr_d = tmr_q + `I2C_TMR_W'(1);
      rs_d = rs_q;
      mlow_d = mlow_q;
      drv_d = drv_q;
      mst_d = mst_q;
      tx_d = tx_q;
      aph_d = aph_q;
      dir_d = dir_q;
      addr_d = addr_q;
      gc_d = gc_q;
      lost_d = lost_q;
      last_d = last_q;
      ack_d = ack_q;
      rep_d = rep_q;
      push_d = push_q;
      si_set = 1'b0;
      busy_d = start_seen | (busy_q & ~stop_seen);
      if (control_set_wr) begin
         ctl_d = ctl_d | (control_set_port & `I2C_CTL_SET_MASK);
      end
      if (control_clear_wr) begin
         ctl_d = ctl_d & ~(control_clear_port & `I2C_CTL_CLR_MASK);
      end
      if (data_wr) begin
         hold_d = data_wdata;
      end
      case (state_q)
         i2c_pkg::ST_IDLE: begin
            if (start_seen) begin
               state_d = i2c_pkg::ST_XFER;
               aph_d = 1'b1;
               tx_d = 1'b0;
               cnt_d = 4'h0;
               rs_d = 1'b0;
            end else if (ctl_q[`I2C_CTL_STA] && !busy_q && scl_s && sda_s &&
                         !ctl_q[`I2C_CTL_SI]) begin
               state_d = i2c_pkg::ST_START;
               rep_d = 1'b0;
               drv_d = 1'b0;
               tmr_d = '0;
            end
         end
         i2c_pkg::ST_RST_LO: begin
            if (half_done) begin
               mlow_d = 1'b0;
               tmr_d = '0;
               state_d = i2c_pkg::ST_RST_HI;
            end
         end
         i2c_pkg::ST_RST_HI: begin
            if (!scl_s) begin
               tmr_d = '0;
            end else if (half_done) begin
               drv_d = 1'b0;
               tmr_d = '0;
               state_d = i2c_pkg::ST_START;
            end
         end
         i2c_pkg::ST_START: begin
            if (half_done) begin
               mlow_d = 1'b1;
               code_d = rep_q ? `I2C_SC_RSTART : `I2C_SC_START;
               si_set = 1'b1;
               mst_d = 1'b1;
               aph_d = 1'b1;
               tx_d = 1'b1;
               addr_d = 1'b0;
               lost_d = 1'b0;
               ctl_d[`I2C_CTL_STA] = 1'b0;
               state_d = i2c_pkg::ST_HOLD;
            end
         end
         i2c_pkg::ST_XFER: begin
            if (start_seen || stop_seen) begin
               if ((mst_q || addr_q) && (cnt_q != 4'h0 || rs_q)) begin
                  code_d = `I2C_SC_BUS_ERR;
                  si_set = 1'b1;
                  mst_d = 1'b0;
                  addr_d = 1'b0;
                  mlow_d = 1'b0;
                  drv_d = 1'b1;
                  state_d = i2c_pkg::ST_HOLD;
               end else begin
                  if (addr_q) begin
                     code_d = `I2C_SC_SR_STOP;
                     si_set = 1'b1;
                     addr_d = 1'b0;
                  end
                  state_d = start_seen ? i2c_pkg::ST_XFER : i2c_pkg::ST_IDLE;
                  aph_d = 1'b1;
                  tx_d = 1'b0;
                  cnt_d = 4'h0;
                  rs_d = 1'b0;
                  drv_d = 1'b1;
               end
            end else begin
               // Clock generation waits for the line to read high, so a
               // slave that stretches the clock slows the master down.
               if (mst_q) begin
                  if (mlow_q) begin
                     if (half_done) begin
                        mlow_d = 1'b0;
                        tmr_d = '0;
                     end
                  end else if (!scl_s) begin
                     tmr_d = '0;
                  end else if (half_done) begin
                     mlow_d = 1'b1;
                     tmr_d = '0;
                  end
               end
               if (scl_rise) begin
                  rs_d = 1'b1;
                  sh_d = (cnt_q == 4'h8) ? sh_q : {sh_q[6:0], sda_s};
                  if (cnt_q == 4'h8) begin
                     ack_d = ~sda_s;
                  end else if (mst_q && tx_q && drv_q && !sda_s) begin
                     lost_d = 1'b1;
                     mst_d = 1'b0;
                  end
               end
               if (scl_fall && rs_q) begin
                  rs_d = 1'b0;
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     if (mst_q) begin
                        drv_d = tx_q | ~ctl_q[`I2C_CTL_AA];
                     end else if (aph_q) begin
                        drv_d = ~addr_hit;
                        if (addr_hit) begin
                           addr_d = 1'b1;
                           gc_d = sh_q == `I2C_GC_ADDR;
                           tx_d = sh_q[0] & (sh_q != `I2C_GC_ADDR);
                        end
                     end else begin
                        drv_d = ~(addr_q & ~tx_q & ctl_q[`I2C_CTL_AA]);
                     end
                  end else if (cnt_q == 4'h8) begin
                     drv_d = 1'b1;
                     hold_d = sh_q;
                     state_d = i2c_pkg::ST_POST;
                     push_d = 1'b0;
                     aph_d = 1'b0;
                     lost_d = 1'b0;
                     if (mst_q) begin
                        if (aph_q && dir_q) begin
                           code_d = ack_q ? `I2C_SC_MR_AR_ACK : `I2C_SC_MR_AR_NACK;
                           tx_d = 1'b0;
                        end else if (aph_q) begin
                           code_d = ack_q ? `I2C_SC_MT_AW_ACK : `I2C_SC_MT_AW_NACK;
                        end else if (tx_q) begin
                           code_d = ack_q ? `I2C_SC_MT_D_ACK : `I2C_SC_MT_D_NACK;
                        end else begin
                           code_d = ack_q ? `I2C_SC_MR_D_ACK : `I2C_SC_MR_D_NACK;
                           push_d = 1'b1;
                        end
                     end else if (lost_q) begin
                        if (!addr_q) begin
                           code_d = `I2C_SC_ARB_LOST;
                        end else if (gc_q) begin
                           code_d = `I2C_SC_SR_GC_LOST;
                        end else begin
                           code_d = tx_q ? `I2C_SC_ST_AR_LOST : `I2C_SC_SR_AW_LOST;
                        end
                     end else if (addr_q && aph_q) begin
                        if (gc_q) begin
                           code_d = `I2C_SC_SR_GC;
                        end else begin
                           code_d = tx_q ? `I2C_SC_ST_AR : `I2C_SC_SR_AW;
                        end
                     end else if (addr_q && tx_q) begin
                        if (!ack_q) begin
                           code_d = `I2C_SC_ST_D_NACK;
                           addr_d = 1'b0;
                        end else if (last_q) begin
                           code_d = `I2C_SC_ST_LAST;
                           addr_d = 1'b0;
                        end else begin
                           code_d = `I2C_SC_ST_D_ACK;
                        end
                     end else if (addr_q && gc_q) begin
                        code_d = ack_q ? `I2C_SC_GC_D_ACK : `I2C_SC_GC_D_NACK;
                        push_d = ack_q;
                        addr_d = ack_q;
                     end else if (addr_q) begin
                        code_d = ack_q ? `I2C_SC_SR_D_ACK : `I2C_SC_SR_D_NACK;
                        push_d = ack_q;
                        addr_d = ack_q;
                     end else begin
                        state_d = i2c_pkg::ST_IDLE;
                     end
                  end else begin
                     drv_d = (tx_q && (mst_q || addr_q)) ? sh_q[7] : 1'b1;
                  end
               end
            end
         end
         i2c_pkg::ST_POST: begin
            if (!push_q || buf_ready) begin
               si_set = 1'b1;
               state_d = i2c_pkg::ST_HOLD;
            end
         end
         i2c_pkg::ST_HOLD: begin
            tmr_d = '0;
            if (!ctl_q[`I2C_CTL_SI]) begin
               if (mst_q && ctl_q[`I2C_CTL_STO]) begin
                  state_d = i2c_pkg::ST_STOP_LO;
                  drv_d = 1'b0;
               end else if (mst_q && ctl_q[`I2C_CTL_STA]) begin
                  state_d = i2c_pkg::ST_RST_LO;
                  rep_d = 1'b1;
               end else if (mst_q || addr_q) begin
                  state_d = i2c_pkg::ST_XFER;
                  cnt_d = 4'h0;
                  rs_d = 1'b0;
                  drv_d = tx_q ? hold_q[7] : 1'b1;
                  last_d = ~ctl_q[`I2C_CTL_AA];
                  if (tx_q) begin
                     sh_d = hold_q;
                  end
                  if (aph_q) begin
                     dir_d = hold_q[0];
                  end
               end else begin
                  ctl_d[`I2C_CTL_STO] = 1'b0;
                  state_d = i2c_pkg::ST_IDLE;
               end
            end
         end
         i2c_pkg::ST_STOP_LO: begin
            if (half_done) begin
               mlow_d = 1'b0;
               tmr_d = '0;
               state_d = i2c_pkg::ST_STOP_HI;
            end
         end
         i2c_pkg::ST_STOP_HI: begin
            if (!scl_s) begin
               tmr_d = '0;
            end else if (half_done) begin
               drv_d = 1'b1;
               mst_d = 1'b0;
               ctl_d[`I2C_CTL_STO] = 1'b0;
               state_d = i2c_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = i2c_pkg::ST_IDLE;
         end
      endcase
      // Disabling the interface drops every transfer and frees both lines.
      if (!ctl_q[`I2C_CTL_EN]) begin
         state_d = i2c_pkg::ST_IDLE;
         mlow_d = 1'b0;
         drv_d = 1'b1;
         mst_d = 1'b0;
         addr_d = 1'b0;
      end
      // A new event outranks a clear written in the same cycle.
      if (si_set) begin
         ctl_d[`I2C_CTL_SI] = 1'b1;
      end
      scl_oe_d = mlow_d | (addr_d & (state_d == i2c_pkg::ST_POST ||
                                     state_d == i2c_pkg::ST_HOLD));
      sda_oe_d = ~drv_d;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= i2c_pkg::ST_IDLE;
         ctl_q <= `I2C_CTL_RESET;
         code_q <= `I2C_CODE_RESET;
         hold_q <= 8'h00;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         tmr_q <= '0;
         {rs_q, mlow_q, mst_q, tx_q, aph_q, dir_q, addr_q, gc_q} <= 8'h00;
         {lost_q, last_q, ack_q, rep_q, busy_q, push_q} <= 6'h00;
         drv_q <= 1'b1;
         {scl_p_q, sda_p_q} <= 2'h3;
         {scl_oe_q, sda_oe_q} <= 2'h0;
      end else begin
         state_q <= state_d;
         ctl_q <= ctl_d;
         code_q <= code_d;
         hold_q <= hold_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         tmr_q <= tmr_d;
         {rs_q, mlow_q, mst_q, tx_q, aph_q, dir_q, addr_q, gc_q} <=
            {rs_d, mlow_d, mst_d, tx_d, aph_d, dir_d, addr_d, gc_d};
         {lost_q, last_q, ack_q, rep_q, busy_q, push_q} <=
            {lost_d, last_d, ack_d, rep_d, busy_d, push_d};
         drv_q <= drv_d;
         {scl_p_q, sda_p_q} <= {scl_s, sda_s};
         {scl_oe_q, sda_oe_q} <= {scl_oe_d, sda_oe_d};
      end
   end

   // Open-drain pins: the driven level is always low.
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;
   assign bus_state_code = code_q;
   assign byte_shift_holder = hold_q;
   assign interrupt_flag = ctl_q[`I2C_CTL_SI];
   assign assert_ack_bit = ctl_q[`I2C_CTL_AA];
   assign start_request_bit = ctl_q[`I2C_CTL_STA];
   assign stop_request_bit = ctl_q[`I2C_CTL_STO];
   assign interface_enable = ctl_q[`I2C_CTL_EN];
endmodule
`default_nettype wire

/* logic/i2c_sync3.sv */
// Three-stage input synchroniser with an agreement filter.
// Assumes asynchronous inputs that idle high.
`timescale 1ns/1ps
`default_nettype none
module i2c_sync3 #(
   parameter int W = 2
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;

   // A change is taken only once the second and third stages agree.
   always_comb begin
      filt_d = filt_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            filt_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         filt_q <= '1;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   assign level = filt_q;
endmodule
`default_nettype wire

/* verification/i2c_bus_slave_model.sv */
// Behavioural bus slave that answers reads with a fixed byte.
// Assumes pulled-up lines; it never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_slave_model #(
   parameter logic [6:0] ADDR = 7'h50,
   parameter logic [7:0] RD_BYTE = 8'ha5
) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull
);
   int bitc = 0;
   logic [7:0] sh = 8'h00;
   logic act = 0;
   logic first = 0;
   logic rd = 0;
   initial sda_pull = 0;
   always @(negedge sda) if (scl) begin
      act = 1;
      first = 1;
      bitc = 0;
   end
   always @(posedge sda) if (scl) act = 0;
   // A master nack on a read byte ends our turn before we drive again.
   always @(posedge scl) if (act) begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else if (rd && !first && sda) act = 0;
      bitc = bitc + 1;
   end
   always @(negedge scl) begin
      if (!act) sda_pull = 0;
      else if (bitc == 8 && first) begin
         rd = sh[0];
         act = (sh[7:1] == ADDR);
         sda_pull = act;
      end
      else if (bitc == 8) sda_pull = !rd;
      else if (bitc == 9) begin
         bitc = 0;
         first = 0;
         sda_pull = rd && !RD_BYTE[7];
      end
      else if (rd && !first && bitc > 0) sda_pull = !RD_BYTE[7 - bitc];
   end
endmodule
`default_nettype wire

/* verification/i2c_sm_properties.sv */
// Port-level checker for the status-code controller.
// Assumes binding to the controller top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module i2c_sm_properties (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic control_set_wr,
   input wire logic [7:0] control_set_port,
   input wire logic control_clear_wr,
   input wire logic [7:0] control_clear_port,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic [7:0] bus_state_code,
   input wire logic interrupt_flag,
   input wire logic assert_ack_bit,
   input wire logic start_request_bit,
   input wire logic interface_enable,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   property p_set;
      control_set_wr && control_set_port[2] && !(control_clear_wr && control_clear_port[2])
         |=> assert_ack_bit;
   endproperty
   a_set: assert property (p_set) else $error("ack bit not set");
   property p_clr;
      control_clear_wr && control_clear_port[2] |=> !assert_ack_bit;
   endproperty
   a_clr: assert property (p_clr) else $error("ack bit not cleared");
   property p_keep;
      !control_set_wr && !control_clear_wr |=> $stable(assert_ack_bit) && $stable(interface_enable);
   endproperty
   a_keep: assert property (p_keep) else $error("control bit moved");
   // Master codes only: an unaddressed slave must not stall the bus.
   property p_hold;
      interrupt_flag && bus_state_code inside {8'h08, 8'h10, 8'h40, 8'h48, 8'h50, 8'h58}
         |-> scl_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("clock not held");
   property p_sta;
      $rose(interrupt_flag) && bus_state_code inside {8'h08, 8'h10} |-> ##[0:2] !start_request_bit;
   endproperty
   a_sta: assert property (p_sta) else $error("start request kept");
   property p_err;
      interrupt_flag && bus_state_code == 8'h00 |-> !scl_oe && !sda_oe;
   endproperty
   a_err: assert property (p_err) else $error("bus error lines held");
   property p_lost;
      interrupt_flag && bus_state_code == 8'h38 |-> !scl_oe && !sda_oe;
   endproperty
   a_lost: assert property (p_lost) else $error("lost bus held");
   property p_mrack;
      $rose(interrupt_flag) && bus_state_code == 8'h50 |-> assert_ack_bit;
   endproperty
   a_mrack: assert property (p_mrack) else $error("ack without ack bit");
   property p_mrnack;
      $rose(interrupt_flag) && bus_state_code == 8'h58 |-> !assert_ack_bit;
   endproperty
   a_mrnack: assert property (p_mrnack) else $error("nack with ack bit");
   property p_rx;
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
   endproperty
   a_rx: assert property (p_rx) else $error("stalled byte lost");
endmodule
bind i2c_status_state_machine i2c_sm_properties chk_inst (.sys_clk, .resetn,
   .control_set_wr, .control_set_port, .control_clear_wr, .control_clear_port,
   .scl_oe, .sda_oe, .bus_state_code, .interrupt_flag, .assert_ack_bit,
   .start_request_bit, .interface_enable, .rx_data, .rx_valid, .rx_ready);
`default_nettype wire

/* verification/i2c_status_state_machine_tb.sv */
// Bench: master read with ack and nack, restart, nacked address, stop.
// Assumes the slave model at address 0x50 on pulled-up lines.
`timescale 1ns/1ps
`default_nettype none
module i2c_status_state_machine_tb;
   logic sys_clk = 0, resetn = 0, set_wr = 0, clr_wr = 0, dat_wr = 0, rx_ready = 0;
   logic [7:0] set_v = 8'h00, clr_v = 8'h00, dat_v = 8'h00, code, holder, rx_data;
   logic scl_oe, sda_oe, sda_pull, flag, ack_b, sta_b, sto_b, en_b, rx_valid;
   wire logic scl = !scl_oe;
   wire logic sda = !(sda_oe || sda_pull);
   int n_errors = 0, checked = 0, i;
   i2c_status_state_machine i2c_status_state_machine_inst (.sys_clk(sys_clk),
      .resetn(resetn), .control_set_wr(set_wr), .control_set_port(set_v),
      .control_clear_wr(clr_wr), .control_clear_port(clr_v), .data_wr(dat_wr),
      .data_wdata(dat_v), .own_address(7'h2a), .general_call_en(1'b0), .scl_i(scl),
      .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .bus_state_code(code), .byte_shift_holder(holder), .interrupt_flag(flag),
      .assert_ack_bit(ack_b), .start_request_bit(sta_b), .stop_request_bit(sto_b),
      .interface_enable(en_b), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
   i2c_bus_slave_model i2c_bus_slave_model_inst (.scl(scl), .sda(sda), .sda_pull(sda_pull));
   initial forever #2.5 sys_clk = !sys_clk;
   ////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic setp(input logic [7:0] v);
      @(negedge sys_clk) {set_wr, set_v} = {1'b1, v};
      @(negedge sys_clk) set_wr = 0;
   endtask
   task automatic clrp(input logic [7:0] v);
      @(negedge sys_clk) {clr_wr, clr_v} = {1'b1, v};
      @(negedge sys_clk) clr_wr = 0;
   endtask
   task automatic wr(input logic [7:0] v);
      @(negedge sys_clk) {dat_wr, dat_v} = {1'b1, v};
      @(negedge sys_clk) dat_wr = 0;
   endtask
   // Bounded so a silent bus ends the run instead of hanging it.
   task automatic wait_flag;
      for (i = 0; i < 5000 && flag !== 1'b1; i++) @(negedge sys_clk);
      if (flag !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: no status posted", $time);
         close_out;
      end
   endtask
   task automatic take;
      @(negedge sys_clk) rx_ready = 1;
      @(negedge sys_clk) rx_ready = 0;
   endtask
   initial begin
      repeat (5) @(negedge sys_clk);
      resetn = 1;
      repeat (4) @(negedge sys_clk);
      chk(code, 8'hf8);
      chk({3'h0, en_b, sta_b, sto_b, ack_b, flag}, 8'h00);
      setp(8'h44);
      chk({6'h0, en_b, ack_b}, 8'h03);
      setp(8'h00);
      chk({6'h0, en_b, ack_b}, 8'h03);
      clrp(8'h0c);
      chk({6'h0, en_b, ack_b}, 8'h02);
      setp(8'h04);
      chk({6'h0, en_b, ack_b}, 8'h03);
      setp(8'h24);
      wait_flag;
      chk(code, 8'h08);
      wr(8'ha1);
      clrp(8'h08);
      wait_flag;
      chk(code, 8'h40);
      clrp(8'h08);
      wait_flag;
      chk(code, 8'h50);
      clrp(8'h0c);
      wait_flag;
      chk(code, 8'h58);
      chk(holder, 8'ha5);
      chk({7'h0, rx_valid}, 8'h01);
      chk(rx_data, 8'ha5);
      take;
      chk(rx_data, 8'ha5);
      take;
      chk({7'h0, rx_valid}, 8'h00);
      setp(8'h24);
      clrp(8'h08);
      wait_flag;
      chk(code, 8'h10);
      wr(8'ha3);
      clrp(8'h08);
      wait_flag;
      chk(code, 8'h48);
      setp(8'h14);
      chk({7'h0, sto_b}, 8'h01);
      clrp(8'h08);
      for (i = 0; i < 2000 && sto_b !== 1'b0; i++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      chk({6'h0, sto_b, flag}, 8'h00);
      chk({6'h0, scl, sda}, 8'h03);
      close_out;
   end
endmodule
`default_nettype wire
